// *** hw/dtc_edge_detect.sv ***
// Falling-edge sampler for an external count pin
`timescale 1ns/1ps
module dtc_edge_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_en,
  input wire logic pin,
  output logic edge_pulse
);
  logic prev_ff;
  logic pulse_ff;
  logic detect;

  // High sample then low sample at timer rate
  assign detect = sample_en & prev_ff & ~pin;
  assign edge_pulse = pulse_ff;

  // R3: pin sampled on ticks; pulse lags detection one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end
    else
    begin
      if (sample_en)
        prev_ff <= pin;
      pulse_ff <= detect;
    end
  end

  property p_edge_late;
    @(posedge pclk) disable iff (!presetn)
    (sample_en && prev_ff && !pin) |=> edge_pulse ##1 !edge_pulse;
  endproperty
  a_edge_late: assert property (p_edge_late) else $error("edge pulse not one cycle late"); // R3
endmodule

// *** hw/dtc_pkg.sv ***
// Package with register map, field positions and timing counts of the timer pair
package dtc_pkg;
  // Operating modes of one timer
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_e;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_LOW0 = 8'h08;
  localparam logic [7:0] OFS_LOW1 = 8'h0c;
  localparam logic [7:0] OFS_HIGH0 = 8'h10;
  localparam logic [7:0] OFS_HIGH1 = 8'h14;
  localparam logic [7:0] OFS_AUX = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;

  // Control register fields
  localparam int CTRL_OVF1 = 7;
  localparam int CTRL_RUN1 = 6;
  localparam int CTRL_OVF0 = 5;
  localparam int CTRL_RUN0 = 4;
  // Mode register fields: timer one in [7:4], timer zero in [3:0]
  localparam int MODE_GATE1 = 7;
  localparam int MODE_FUNC1 = 6;
  localparam int MODE_SEL1 = 4;
  localparam int MODE_GATE0 = 3;
  localparam int MODE_FUNC0 = 2;
  localparam int MODE_SEL0 = 0;
  // Auxiliary register fields
  localparam int AUX_FAST0 = 7;
  localparam int AUX_FAST1 = 6;
  localparam int AUX_CKOE1 = 1;
  localparam int AUX_CKOE0 = 0;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // Slow timer rate: one tick per this many system clocks
  localparam logic [3:0] PRESCALE_DIV = 4'hc;
endpackage

// *** hw/dtc_prescale.sv ***
// Divide-by-twelve tick generator for the slow timer rate
`timescale 1ns/1ps
module dtc_prescale (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic wrap;

  // Wrap after the last count of the period
  assign wrap = (cnt_ff == (dtc_pkg::PRESCALE_DIV - 4'h1));
  assign nxt_cnt = wrap ? 4'h0 : cnt_ff + 4'h1;
  assign tick = wrap;

  // Free-running so both timers share one phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end

  property p_tick_period;
    @(posedge pclk) disable iff (!presetn)
    tick |=> (!tick)[*8] ##1 !tick ##1 !tick ##1 !tick ##1 tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period not twelve"); // R1
endmodule

// *** hw/dtc_top.sv ***
// Dual timer/counter pair with APB register access
//
// Behaviour
// R1: Timer ticks every twelve clocks, or each clock
// R2: Counter samples pin, counts high-then-low transitions
// R3: Counted edge lands one cycle after detection
// R4: Mode zero: 13-bit count, rollover sets flag
// R5: Count only if run and gate allows
// R6: Mode one: full 16-bit count
// R7: Mode two: low byte reloads from high
// R8: Reload leaves high byte untouched
// R9: Timer one in mode three holds count
// R10: Split mode: low byte uses timer zero controls
// R11: Split high byte: ticks only, timer one's flag
// R12: Clock out divides by 2n times reload span
// R13: Two-bit field selects the four modes
// R14: Vector acknowledge clears flag; software writes it
// R15: Function bit selects internal tick or pin
// R16: Clock output enable drives the pin; here only while the function bit selects the timer
// R17: Thirteen bits: high byte plus low five bits
// R18: Clock out toggles on each reload overflow
`timescale 1ns/1ps
module dtc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_pin_zero,
  input wire logic count_pin_one,
  input wire logic external_gate_pin_zero,
  input wire logic external_gate_pin_one,
  input wire logic vector_ack_zero,
  input wire logic vector_ack_one,
  output logic overflow_flag_zero,
  output logic overflow_flag_one,
  output logic clock_out_zero,
  output logic clock_out_zero_oe,
  output logic clock_out_one,
  output logic clock_out_one_oe,
  output logic irq
);
  logic [7:0] low0_ff;
  logic [7:0] high0_ff;
  logic [7:0] low1_ff;
  logic [7:0] high1_ff;
  logic [7:0] mode_ff;
  logic [7:0] aux_ff;
  logic run0_ff;
  logic run1_ff;
  logic ovf0_ff;
  logic ovf1_ff;
  logic clk0_ff;
  logic clk1_ff;
  logic [1:0] status_ff;
  logic [1:0] mask_ff;
  logic [31:0] rdata_ff;

  logic [7:0] nxt_low0;
  logic [7:0] nxt_high0;
  logic [7:0] nxt_low1;
  logic [7:0] nxt_high1;
  logic nxt_ovf0;
  logic nxt_ovf1;
  logic [1:0] nxt_status;
  logic [31:0] nxt_rdata;

  // One increment in the given mode: {overflow, high, low}
  function automatic logic [16:0] dtc_step(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [12:0] s13;
    logic [15:0] s16;
    logic [16:0] res;
    s13 = {hi, lo[4:0]} + 13'h1;
    s16 = {hi, lo} + 16'h1;
    res = {1'b0, hi, lo};
    // R13: mode field decode
    case (mode)
      // R17: high byte over low five bits
      dtc_pkg::DTC_MODE_13: res = {&{hi, lo[4:0]}, s13[12:5], lo[7:5], s13[4:0]};
      dtc_pkg::DTC_MODE_16: res = {&{hi, lo}, s16};
      // R7: overflow reloads low byte; R8: high byte kept
      dtc_pkg::DTC_MODE_RELOAD: res = {&lo, hi, (&lo) ? hi : lo + 8'h1};
      default: res = {&lo, hi, lo + 8'h1};
    endcase
    return res;
  endfunction

  // Bus phase and address decode
  logic setup_ph;
  logic access_ph;
  logic hit;
  logic wr;
  logic rd;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit = (paddr == dtc_pkg::OFS_CTRL) || (paddr == dtc_pkg::OFS_MODE) ||
    (paddr == dtc_pkg::OFS_LOW0) || (paddr == dtc_pkg::OFS_LOW1) ||
    (paddr == dtc_pkg::OFS_HIGH0) || (paddr == dtc_pkg::OFS_HIGH1) ||
    (paddr == dtc_pkg::OFS_AUX) || (paddr == dtc_pkg::OFS_STATUS) ||
    (paddr == dtc_pkg::OFS_MASK);
  assign wr = access_ph & pwrite & hit;
  assign rd = access_ph & ~pwrite & hit;

  logic wr_ctrl;
  logic wr_mode;
  logic wr_low0;
  logic wr_low1;
  logic wr_high0;
  logic wr_high1;
  logic wr_aux;
  logic wr_mask;
  logic rd_status;
  assign wr_ctrl = wr & (paddr == dtc_pkg::OFS_CTRL);
  assign wr_mode = wr & (paddr == dtc_pkg::OFS_MODE);
  assign wr_low0 = wr & (paddr == dtc_pkg::OFS_LOW0);
  assign wr_low1 = wr & (paddr == dtc_pkg::OFS_LOW1);
  assign wr_high0 = wr & (paddr == dtc_pkg::OFS_HIGH0);
  assign wr_high1 = wr & (paddr == dtc_pkg::OFS_HIGH1);
  assign wr_aux = wr & (paddr == dtc_pkg::OFS_AUX);
  assign wr_mask = wr & (paddr == dtc_pkg::OFS_MASK);
  assign rd_status = rd & (paddr == dtc_pkg::OFS_STATUS);

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit;

  // Field views of the configuration registers
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic func0;
  logic func1;
  logic gate0;
  logic gate1;
  logic fast0;
  logic fast1;
  logic split0;
  assign mode0 = mode_ff[dtc_pkg::MODE_SEL0 +: 2];
  assign mode1 = mode_ff[dtc_pkg::MODE_SEL1 +: 2];
  assign func0 = mode_ff[dtc_pkg::MODE_FUNC0];
  assign func1 = mode_ff[dtc_pkg::MODE_FUNC1];
  assign gate0 = mode_ff[dtc_pkg::MODE_GATE0];
  assign gate1 = mode_ff[dtc_pkg::MODE_GATE1];
  assign fast0 = aux_ff[dtc_pkg::AUX_FAST0];
  assign fast1 = aux_ff[dtc_pkg::AUX_FAST1];
  assign split0 = (mode0 == dtc_pkg::DTC_MODE_SPLIT);

  // Timer-rate ticks shared by timer and counter functions
  logic tick12;
  logic tick0;
  logic tick1;
  logic edge0;
  logic edge1;

  dtc_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick12)
  );

  // R1: slow or fast tick per timer
  assign tick0 = fast0 | tick12;
  assign tick1 = fast1 | tick12;

  // R2: pins sampled at timer rate
  dtc_edge_detect u_edge0 (
    .pclk(pclk),
    .presetn(presetn),
    .sample_en(tick0),
    .pin(count_pin_zero),
    .edge_pulse(edge0)
  );

  dtc_edge_detect u_edge1 (
    .pclk(pclk),
    .presetn(presetn),
    .sample_en(tick1),
    .pin(count_pin_one),
    .edge_pulse(edge1)
  );

  // Count sources and gating
  logic src0;
  logic src1;
  logic en0;
  logic en1;
  logic inc0;
  logic inc0h;
  logic inc1;
  // R15: function bit picks tick or pin edge
  assign src0 = func0 ? edge0 : tick0;
  assign src1 = func1 ? edge1 : tick1;
  // R5: run bit and gate qualify the input
  assign en0 = run0_ff & (~gate0 | external_gate_pin_zero);
  assign en1 = run1_ff & (~gate1 | external_gate_pin_one);
  // R10: low byte keeps timer zero's controls in split mode
  assign inc0 = src0 & en0;
  // R11: split high byte runs on ticks under timer one's run bit
  assign inc0h = split0 & tick0 & run1_ff;
  // R9: timer one stops in mode three
  assign inc1 = src1 & en1 & (mode1 != dtc_pkg::DTC_MODE_SPLIT);

  // Stepped values for both timers
  logic [16:0] step0;
  logic [16:0] step1;
  logic ovf_ev0;
  logic ovf_ev1;
  logic tog0;
  logic tog1;
  assign step0 = dtc_step(mode0, low0_ff, high0_ff);
  assign step1 = dtc_step(mode1, low1_ff, high1_ff);
  // R4: rollover sets overflow event
  assign ovf_ev0 = inc0 & step0[16];
  // R11: split high byte takes over timer one's flag
  assign ovf_ev1 = split0 ? (inc0h & (&high0_ff)) : (inc1 & step1[16]);
  // R18: toggle on each auto-reload overflow
  assign tog0 = ovf_ev0 & (mode0 == dtc_pkg::DTC_MODE_RELOAD);
  assign tog1 = inc1 & step1[16] & (mode1 == dtc_pkg::DTC_MODE_RELOAD);

  // Count next values; a software write beats a same-cycle count
  // R6: 16-bit and other modes via the step function, except the split high byte
  assign nxt_low0 = wr_low0 ? pwdata[7:0] : (inc0 ? step0[7:0] : low0_ff);
  assign nxt_high0 = wr_high0 ? pwdata[7:0] :
    split0 ? (inc0h ? high0_ff + 8'h1 : high0_ff) :
    (inc0 ? step0[15:8] : high0_ff);
  assign nxt_low1 = wr_low1 ? pwdata[7:0] : (inc1 ? step1[7:0] : low1_ff);
  assign nxt_high1 = wr_high1 ? pwdata[7:0] : (inc1 ? step1[15:8] : high1_ff);

  // R14: hardware set wins, then software write, then vector clear
  assign nxt_ovf0 = ovf_ev0 ? 1'b1 :
    (wr_ctrl ? pwdata[dtc_pkg::CTRL_OVF0] : (vector_ack_zero ? 1'b0 : ovf0_ff));
  assign nxt_ovf1 = ovf_ev1 ? 1'b1 :
    (wr_ctrl ? pwdata[dtc_pkg::CTRL_OVF1] : (vector_ack_one ? 1'b0 : ovf1_ff));

  // Sticky events; a read clears but a new event still lands
  assign nxt_status = {ovf_ev1, ovf_ev0} | (rd_status ? 2'h0 : status_ff);

  // Read data mux, captured in the setup phase
  assign nxt_rdata =
    (paddr == dtc_pkg::OFS_CTRL) ? {24'h0, ovf1_ff, run1_ff, ovf0_ff, run0_ff, 4'h0} :
    (paddr == dtc_pkg::OFS_MODE) ? {24'h0, mode_ff} :
    (paddr == dtc_pkg::OFS_LOW0) ? {24'h0, low0_ff} :
    (paddr == dtc_pkg::OFS_LOW1) ? {24'h0, low1_ff} :
    (paddr == dtc_pkg::OFS_HIGH0) ? {24'h0, high0_ff} :
    (paddr == dtc_pkg::OFS_HIGH1) ? {24'h0, high1_ff} :
    (paddr == dtc_pkg::OFS_AUX) ? {24'h0, aux_ff[7:6], 4'h0, aux_ff[1:0]} :
    (paddr == dtc_pkg::OFS_STATUS) ? {30'h0, status_ff} :
    (paddr == dtc_pkg::OFS_MASK) ? {30'h0, mask_ff} : 32'h0;

  // Count registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low0_ff <= dtc_pkg::RST_BYTE;
      high0_ff <= dtc_pkg::RST_BYTE;
      low1_ff <= dtc_pkg::RST_BYTE;
      high1_ff <= dtc_pkg::RST_BYTE;
    end
    else
    begin
      low0_ff <= nxt_low0;
      high0_ff <= nxt_high0;
      low1_ff <= nxt_low1;
      high1_ff <= nxt_high1;
    end
  end

  // Control, configuration and flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= dtc_pkg::RST_BYTE;
      aux_ff <= dtc_pkg::RST_BYTE;
      run0_ff <= 1'b0;
      run1_ff <= 1'b0;
      ovf0_ff <= 1'b0;
      ovf1_ff <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        mode_ff <= pwdata[7:0];
      if (wr_aux)
        aux_ff <= pwdata[7:0];
      if (wr_ctrl)
        run0_ff <= pwdata[dtc_pkg::CTRL_RUN0];
      if (wr_ctrl)
        run1_ff <= pwdata[dtc_pkg::CTRL_RUN1];
      ovf0_ff <= nxt_ovf0;
      ovf1_ff <= nxt_ovf1;
    end
  end

  // Interrupt status, mask and read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= dtc_pkg::RST_IRQ;
      mask_ff <= dtc_pkg::RST_IRQ;
      rdata_ff <= 32'h0;
    end
    else
    begin
      status_ff <= nxt_status;
      if (wr_mask)
        mask_ff <= pwdata[1:0];
      if (setup_ph)
        rdata_ff <= nxt_rdata;
    end
  end

  // R12: toggling on reload overflow halves the overflow rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk0_ff <= 1'b0;
      clk1_ff <= 1'b0;
    end
    else
    begin
      if (tog0)
        clk0_ff <= ~clk0_ff;
      if (tog1)
        clk1_ff <= ~clk1_ff;
    end
  end

  // Outputs
  assign prdata = rdata_ff;
  assign overflow_flag_zero = ovf0_ff;
  assign overflow_flag_one = ovf1_ff;
  assign irq = |(status_ff & mask_ff);
  assign clock_out_zero = clk0_ff;
  assign clock_out_one = clk1_ff;
  // R16: pin driven only with enable set and timer function
  assign clock_out_zero_oe = aux_ff[dtc_pkg::AUX_CKOE0] & ~func0;
  assign clock_out_one_oe = aux_ff[dtc_pkg::AUX_CKOE1] & ~func1;

  // Checks
  property p_mode13_ovf;
    @(posedge pclk) disable iff (!presetn)
    (inc0 && mode0 == dtc_pkg::DTC_MODE_13 && &{high0_ff, low0_ff[4:0]} && !wr_ctrl)
      |=> ovf0_ff && high0_ff == 8'h00 && low0_ff[4:0] == 5'h00;
  endproperty
  a_mode13_ovf: assert property (p_mode13_ovf) else $error("13-bit rollover wrong"); // R4

  property p_gate_hold;
    @(posedge pclk) disable iff (!presetn)
    (!run0_ff && !wr_low0 && !split0) |=> $stable(low0_ff);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved while stopped"); // R5

  property p_mode16_inc;
    @(posedge pclk) disable iff (!presetn)
    (inc1 && mode1 == dtc_pkg::DTC_MODE_16 && !wr_low1 && !wr_high1)
      |=> {high1_ff, low1_ff} == $past({high1_ff, low1_ff}) + 16'h1;
  endproperty
  a_mode16_inc: assert property (p_mode16_inc) else $error("16-bit step wrong"); // R6

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    (inc0 && mode0 == dtc_pkg::DTC_MODE_RELOAD && low0_ff == 8'hff && !wr_low0 && !wr_high0)
      |=> low0_ff == $past(high0_ff) && $stable(high0_ff);
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong"); // R7

  property p_one_stop;
    @(posedge pclk) disable iff (!presetn)
    (mode1 == dtc_pkg::DTC_MODE_SPLIT && !wr_low1 && !wr_high1) |=> $stable({high1_ff, low1_ff});
  endproperty
  a_one_stop: assert property (p_one_stop) else $error("timer one moved in mode three"); // R9

  property p_split_high;
    @(posedge pclk) disable iff (!presetn)
    (inc0h && high0_ff == 8'hff && !wr_high0) |=> ovf1_ff && high0_ff == 8'h00;
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high overflow lost"); // R11

  property p_vector_clear;
    @(posedge pclk) disable iff (!presetn)
    (vector_ack_zero && !ovf_ev0 && !wr_ctrl) |=> !ovf0_ff;
  endproperty
  a_vector_clear: assert property (p_vector_clear) else $error("flag not cleared"); // R14

  property p_clk_toggle;
    @(posedge pclk) disable iff (!presetn)
    tog0 |=> clock_out_zero != $past(clock_out_zero);
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("clock out missed toggle"); // R18

  property p_oe_off;
    @(posedge pclk) disable iff (!presetn)
    !aux_ff[dtc_pkg::AUX_CKOE1] |-> !clock_out_one_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("clock out driven while disabled"); // R16

  c_reload: cover property (@(posedge pclk) disable iff (!presetn) tog0);
  c_split: cover property (@(posedge pclk) disable iff (!presetn) inc0h && ovf_ev1);
  c_edge: cover property (@(posedge pclk) disable iff (!presetn) func0 && inc0);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

// *** testbench/dtc_pin_model.sv ***
// Pin-side model: falling-edge bursts on the count pins, gate levels
`timescale 1ns/1ps
module dtc_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic burst_go,
  input wire logic burst_sel,
  input wire logic [7:0] burst_len,
  input wire logic [7:0] half_len,
  input wire logic [1:0] gate_lvl,
  output logic busy,
  output logic count_pin_zero,
  output logic count_pin_one,
  output logic external_gate_pin_zero,
  output logic external_gate_pin_one
);
  logic [1:0] pin_ff;
  logic [8:0] left_ff;
  logic [7:0] hold_ff;
  logic sel_ff;
  // Pins idle high; each level held half_len clocks, so a half
  // period shorter than one timer tick would lose edges
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_ff <= 2'h3;
      left_ff <= 9'h000;
      hold_ff <= 8'h00;
      sel_ff <= 1'b0;
    end
    else if (burst_go && left_ff == 9'h000)
    begin
      left_ff <= {burst_len, 1'b0};
      hold_ff <= half_len;
      sel_ff <= burst_sel;
    end
    else if (left_ff != 9'h000)
    begin
      if (hold_ff > 8'h01)
        hold_ff <= hold_ff - 8'h01;
      else
      begin
        pin_ff[sel_ff] <= ~pin_ff[sel_ff];
        left_ff <= left_ff - 9'h001;
        hold_ff <= half_len;
      end
    end
  end
  // Outputs straight from the model state; gate pins straight from gate_lvl
  assign busy = left_ff != 9'h000;
  assign count_pin_zero = pin_ff[0];
  assign count_pin_one = pin_ff[1];
  assign external_gate_pin_zero = gate_lvl[0];
  assign external_gate_pin_one = gate_lvl[1];
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the timer pair over APB
`timescale 1ns/1ps
`define chk(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, len = 8'h00, half = 8'h00, q;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, err, busy, ack0 = 1'b0, ack1 = 1'b0, go = 1'b0, sel = 1'b0;
  logic cp0, cp1, gp0, gp1, f0, f1, co0, oe0, co1, oe1, irq;
  logic [1:0] gate = 2'h3;
  int mismatches = 0, checks_done = 0, n, i;
  // Clock at 50 MHz
  always #10 pclk = ~pclk;
  dtc_pin_model pins (.pclk(pclk), .presetn(presetn), .burst_go(go), .burst_sel(sel),
    .burst_len(len), .half_len(half), .gate_lvl(gate), .busy(busy),
    .count_pin_zero(cp0), .count_pin_one(cp1), .external_gate_pin_zero(gp0),
    .external_gate_pin_one(gp1));
  dtc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin_zero(cp0), .count_pin_one(cp1),
    .external_gate_pin_zero(gp0), .external_gate_pin_one(gp1), .vector_ack_zero(ack0),
    .vector_ack_one(ack1), .overflow_flag_zero(f0), .overflow_flag_one(f1),
    .clock_out_zero(co0), .clock_out_zero_oe(oe0), .clock_out_one(co1),
    .clock_out_one_oe(oe1), .irq(irq));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // A wait loop that used up its bound ends the run as a failure
  task automatic timeout_check(input int lim);
    if (n >= lim)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      mismatches++;
      tally_and_finish();
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  // Start with a control write, count clocks until the chosen flag rises
  task automatic go_flag(input logic [7:0] c, input logic which);
    wr(dtc_pkg::OFS_CTRL, c);
    for (n = 0; n < 600; n++)
    begin
      @(negedge pclk);
      if ((which ? f1 : f0) === 1'b1)
        break;
    end
    timeout_check(600);
  endtask
  // Clocks between two toggles of the chosen clock out; first toggle skipped
  task automatic gap(input logic which);
    logic v;
    v = which ? co1 : co0;
    for (n = 0; n < 500 && (which ? co1 : co0) === v; n++)
      @(negedge pclk);
    timeout_check(500);
    v = which ? co1 : co0;
    for (n = 1; n < 500; n++)
    begin
      @(negedge pclk);
      if ((which ? co1 : co0) !== v)
        break;
    end
    timeout_check(500);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(dtc_pkg::OFS_MODE);
    `chk(q, 8'h00)
    rd(8'h40);
    `chk({err, q}, 9'h100)
    // Mode zero: only 2 ticks from 0x1ffe to rollover
    wr(dtc_pkg::OFS_HIGH0, 8'hff);
    wr(dtc_pkg::OFS_LOW0, 8'hfe);
    wr(dtc_pkg::OFS_AUX, 8'h80);
    go_flag(8'h10, 1'b0);
    `chk(n inside {[0:4]}, 1'b1)
    rd(dtc_pkg::OFS_HIGH0);
    `chk(q, 8'h00)
    rd(dtc_pkg::OFS_LOW0);
    `chk(q[7:5], 3'h7)
    // Mode one: 0xff1e needs 226 ticks
    wr(dtc_pkg::OFS_CTRL, 8'h00);
    wr(dtc_pkg::OFS_LOW0, 8'h1e);
    wr(dtc_pkg::OFS_HIGH0, 8'hff);
    wr(dtc_pkg::OFS_MODE, 8'h01);
    go_flag(8'h10, 1'b0);
    `chk(n inside {[222:230]}, 1'b1)
    // Mode two and clock out at both rates; reload span 16
    for (i = 0; i < 2; i++)
    begin
      wr(dtc_pkg::OFS_CTRL, 8'h00);
      wr(dtc_pkg::OFS_HIGH0, 8'hf0);
      wr(dtc_pkg::OFS_LOW0, 8'hfe);
      wr(dtc_pkg::OFS_MODE, 8'h02);
      wr(dtc_pkg::OFS_AUX, i ? 8'h01 : 8'h81);
      go_flag(8'h10, 1'b0);
      rd(dtc_pkg::OFS_LOW0);
      `chk(q[7:4], 4'hf)
      rd(dtc_pkg::OFS_HIGH0);
      `chk(q, 8'hf0)
      `chk(oe0, 1'b1)
      gap(1'b0);
      `chk(n, i ? 192 : 16)
      wr(dtc_pkg::OFS_AUX, 8'h80);
      @(negedge pclk);
      `chk(oe0, 1'b0)
    end
    // Gate pin low blocks counting, high lets it through
    wr(dtc_pkg::OFS_CTRL, 8'h00);
    wr(dtc_pkg::OFS_LOW0, 8'h00);
    wr(dtc_pkg::OFS_MODE, 8'h09);
    gate <= 2'h2;
    wr(dtc_pkg::OFS_CTRL, 8'h10);
    repeat (40) @(posedge pclk);
    rd(dtc_pkg::OFS_LOW0);
    `chk(q, 8'h00)
    gate <= 2'h3;
    repeat (40) @(posedge pclk);
    rd(dtc_pkg::OFS_LOW0);
    `chk(q != 8'h00, 1'b1)
    // Timer one counts five pin edges; clock out off in counter use
    wr(dtc_pkg::OFS_CTRL, 8'h00);
    wr(dtc_pkg::OFS_MODE, 8'h50);
    wr(dtc_pkg::OFS_AUX, 8'h42);
    wr(dtc_pkg::OFS_LOW1, 8'h00);
    wr(dtc_pkg::OFS_HIGH1, 8'h00);
    wr(dtc_pkg::OFS_CTRL, 8'h40);
    @(negedge pclk);
    `chk(oe1, 1'b0)
    @(posedge pclk);
    sel <= 1'b1;
    len <= 8'h05;
    half <= 8'h03;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    for (n = 0; n < 200 && busy === 1'b1; n++)
      @(negedge pclk);
    timeout_check(200);
    repeat (4) @(posedge pclk);
    rd(dtc_pkg::OFS_LOW1);
    `chk(q, 8'h05)
    // Timer one in mode three holds with run set
    wr(dtc_pkg::OFS_MODE, 8'h30);
    repeat (20) @(posedge pclk);
    rd(dtc_pkg::OFS_LOW1);
    `chk(q, 8'h05)
    // Split: high byte of timer zero runs on timer one's run bit
    wr(dtc_pkg::OFS_CTRL, 8'h00);
    wr(dtc_pkg::OFS_HIGH0, 8'hfe);
    wr(dtc_pkg::OFS_LOW0, 8'h00);
    wr(dtc_pkg::OFS_AUX, 8'h80);
    wr(dtc_pkg::OFS_MODE, 8'h33);
    go_flag(8'h40, 1'b1);
    `chk(n inside {[0:4]}, 1'b1)
    `chk(f0, 1'b0)
    rd(dtc_pkg::OFS_LOW0);
    `chk(q, 8'h00)
    // Timer one auto-reload drives its own clock out; span 16, fast rate
    wr(dtc_pkg::OFS_CTRL, 8'h00);
    wr(dtc_pkg::OFS_HIGH1, 8'hf0);
    wr(dtc_pkg::OFS_LOW1, 8'hfe);
    wr(dtc_pkg::OFS_MODE, 8'h20);
    wr(dtc_pkg::OFS_AUX, 8'h42);
    wr(dtc_pkg::OFS_CTRL, 8'h40);
    `chk(oe1, 1'b1)
    gap(1'b1);
    `chk(n, 16)
    // Sticky status, mask and interrupt line
    wr(dtc_pkg::OFS_CTRL, 8'h00);
    wr(dtc_pkg::OFS_MASK, 8'h01);
    @(negedge pclk);
    `chk(irq, 1'b1)
    rd(dtc_pkg::OFS_STATUS);
    `chk(q, 8'h03)
    rd(dtc_pkg::OFS_STATUS);
    `chk(q, 8'h00)
    @(negedge pclk);
    `chk(irq, 1'b0)
    // Software sets the flag, vector acknowledge clears it
    wr(dtc_pkg::OFS_CTRL, 8'ha0);
    @(negedge pclk);
    `chk(f0, 1'b1)
    `chk(f1, 1'b1)
    @(posedge pclk);
    ack0 <= 1'b1;
    ack1 <= 1'b1;
    @(posedge pclk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    @(negedge pclk);
    `chk(f0, 1'b0)
    `chk(f1, 1'b0)
    tally_and_finish();
  end
endmodule
